// File: rtl/prd_pkg.sv
package prd_pkg;
	// Counts of PLLs, spread-capable PLLs and post-divided output banks.
	localparam int PRD_NUM_PLL = 3;
	localparam int PRD_NUM_SS = 2;
	localparam int PRD_NUM_BANK = 5;

	// Register byte addresses on the configuration port.
	localparam logic [7:0] PRD_ADDR_DRIVE = 8'h06;
	localparam logic [7:0] PRD_ADDR_LOAD = 8'h07;
	localparam logic [7:0] PRD_ADDR_PRE0 = 8'h10;
	localparam logic [7:0] PRD_ADDR_FB0 = 8'h18;
	localparam logic [7:0] PRD_ADDR_POST0 = 8'h20;
	localparam logic [7:0] PRD_ADDR_OUT1SRC = 8'h2a;
	localparam logic [7:0] PRD_ADDR_REFSEL = 8'h34;
	localparam logic [7:0] PRD_ADDR_MFC = 8'h35;
	localparam logic [7:0] PRD_ADDR_STATUS = 8'h36;
	localparam logic [7:0] PRD_ADDR_TSSC0 = 8'h60;
	localparam logic [7:0] PRD_ADDR_SSOFF0 = 8'h61;
	localparam logic [7:0] PRD_ADDR_SS_STRIDE = 8'h08;

	// Field positions inside the byte registers.
	localparam int PRD_PRIM_BIT = 0;
	localparam int PRD_SM_LSB = 6;
	localparam int PRD_A_LSB = 4;
	localparam int PRD_SRC_LSB = 4;

	// Reset values and fixed constants.
	localparam logic [1:0] PRD_DRIVE_RST = 2'h3;
	localparam logic [7:0] PRD_LOAD_RST = 8'h00;
	localparam logic [7:0] PRD_PRE_RST = 8'h01;
	localparam logic [8:0] PRD_LOAD_BASE = 9'h01c;
	localparam logic [1:0] PRD_MFC_NO_PIN = 2'h2;
	localparam logic [1:0] PRD_SRC_NONE = 2'h3;

	// Software-visible settings.
	typedef struct packed {
		logic [1:0] drive;
		logic [7:0] cap;
		logic primsel;
		logic [1:0] swmode;
		logic [1:0] manual_frequency_control;
		logic [1:0] out1src;
		logic [PRD_NUM_PLL-1:0][7:0] pre;
		logic [PRD_NUM_PLL-1:0][11:0] n;
		logic [PRD_NUM_SS-1:0][3:0] a;
		logic [PRD_NUM_SS-1:0][5:0] ssoff;
		logic [PRD_NUM_SS-1:0][3:0] tssc;
		logic [PRD_NUM_BANK-1:0][9:0] q;
		logic [PRD_NUM_BANK-1:0][1:0] src;
	} prd_cfg_t;

	localparam prd_cfg_t PRD_CFG_RST = '{drive: PRD_DRIVE_RST, cap: PRD_LOAD_RST,
		pre: {PRD_NUM_PLL{PRD_PRE_RST}}, default: '0};

	// Whole state of the block.
	typedef struct packed {
		prd_cfg_t cfg;
		prd_cfg_t act;
		logic sel_aux;
		logic [1:0] ref_prev;
		logic [PRD_NUM_PLL-1:0] vco_prev;
		logic [PRD_NUM_PLL-1:0][7:0] pre_cnt;
		logic [PRD_NUM_PLL-1:0] pfd;
		logic [PRD_NUM_PLL-1:0] pwr;
		logic [PRD_NUM_BANK-1:0][10:0] post_cnt;
		logic [PRD_NUM_BANK-1:0] bank;
		logic out1;
		logic [PRD_NUM_SS-1:0][19:0] fb;
		logic [11:0] fb2;
		logic [8:0] load;
		logic [7:0] rdata;
	} prd_state_t;
endpackage

// File: rtl/prd_top.sv
// Notes on behaviour
// - Primary bit 0 crystal input, 1 aux.
// - Select pin low primary, high secondary, while the mode field's upper bit is clear.
// - Pin ignored in manual frequency mode 2.
// - Load is 3.5pF plus code times 0.125pF.
// - Per-PLL 8-bit pre-scaler divides reference.
// - Pre-scaler zero powers PLL and banks down.
// - Ratio is twice coarse plus fine plus one.
// - PLL2 ratio is coarse value alone.
// - Spread on folds offset into ratio.
// - Banks 2-6 post-divide, bank 1 none.
// - Banks 2-6 add fixed divide by two.
// - Divider rewrites may glitch outputs.
`timescale 1ns/1ps
module prd_top
	import prd_pkg::*;
(
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESET,
	// Configuration port.
	input wire logic CFG_WR,
	input wire logic [7:0] CFG_ADDR,
	input wire logic [7:0] CFG_WDATA,
	output logic [7:0] CFG_RDATA,
	// Reference inputs and select pin.
	input wire logic CRYSTAL_OR_REF_INPUT,
	input wire logic AUX_REFERENCE_INPUT,
	input wire logic GENERAL_INPUT_FIVE,
	// Oscillator clocks of the three PLLs.
	input wire logic [PRD_NUM_PLL-1:0] VCO_CLK,
	// Reference and PLL control outputs.
	output logic REF_SELECT_AUX,
	output logic [PRD_NUM_PLL-1:0] PFD_TICK,
	output logic [PRD_NUM_PLL-1:0] PLL_POWERED,
	output logic [19:0] FB_RATIO0_X64,
	output logic [19:0] FB_RATIO1_X64,
	output logic [11:0] FB_RATIO2,
	// Crystal oscillator settings.
	output logic [8:0] CRYSTAL_LOAD_EIGHTHS_PF,
	output logic [1:0] CRYSTAL_DRIVE_STRENGTH,
	// Output bank clocks.
	output logic OUT1_CLK,
	output logic [PRD_NUM_BANK-1:0] BANK_CLK
);

	// Which input should be the reference, given settings and the select pin.
	function automatic logic want_aux(prd_cfg_t c, logic pin);
		logic secondary;
		secondary = !c.swmode[1] && (c.manual_frequency_control != PRD_MFC_NO_PIN) && pin;
		return c.primsel ^ secondary;
	endfunction

	// Feedback ratio of a spread-capable PLL in units of 1/64.
	function automatic logic [19:0] fb_x64(logic [11:0] n, logic [3:0] a, logic [5:0] off,
		logic [3:0] tssc);
		logic [13:0] base;
		// A zero fine code is minus one, which cancels the plus one.
		base = {1'b0, n, 1'b0} + {10'h000, a} + {13'h0000, a != 4'h0};
		return {base, (tssc != 4'h0) ? off : 6'h00};
	endfunction

	// Read decode of the configuration registers.
	function automatic logic [7:0] reg_read(prd_cfg_t c, logic [7:0] stat, logic [7:0] adr);
		logic [7:0] d;
		d = 8'h00;
		case (adr)
			PRD_ADDR_DRIVE: d = {6'h00, c.drive};
			PRD_ADDR_LOAD: d = c.cap;
			PRD_ADDR_REFSEL: d = {c.swmode, 5'h00, c.primsel};
			PRD_ADDR_MFC: d = {6'h00, c.manual_frequency_control};
			PRD_ADDR_OUT1SRC: d = {6'h00, c.out1src};
			PRD_ADDR_STATUS: d = stat;
			default: d = 8'h00;
		endcase
		for (int p = 0; p < PRD_NUM_PLL; p++)
		begin
			if (adr == PRD_ADDR_PRE0 + 8'(p))
				d = c.pre[p];
			if (adr == PRD_ADDR_FB0 + 8'(2 * p))
				d = c.n[p][7:0];
			if (adr == PRD_ADDR_FB0 + 8'(2 * p + 1))
				d = {(p < PRD_NUM_SS) ? c.a[p % PRD_NUM_SS] : 4'h0, c.n[p][11:8]};
		end
		for (int p = 0; p < PRD_NUM_SS; p++)
		begin
			if (adr == PRD_ADDR_TSSC0 + 8'(p) * PRD_ADDR_SS_STRIDE)
				d = {4'h0, c.tssc[p]};
			if (adr == PRD_ADDR_SSOFF0 + 8'(p) * PRD_ADDR_SS_STRIDE)
				d = {2'h0, c.ssoff[p]};
		end
		for (int k = 0; k < PRD_NUM_BANK; k++)
		begin
			if (adr == PRD_ADDR_POST0 + 8'(2 * k))
				d = c.q[k][7:0];
			if (adr == PRD_ADDR_POST0 + 8'(2 * k + 1))
				d = {2'h0, c.src[k], 2'h0, c.q[k][9:8]};
		end
		return d;
	endfunction

	prd_state_t s_r; // Registered state.
	prd_state_t s_nxt; // Next state.
	logic ref_tick; // Rising edge of the selected reference.
	logic [PRD_NUM_PLL-1:0] vco_tick; // Rising edges of the oscillator clocks.
	logic [7:0] status; // Live status byte.

	// Edge detection on the synchronous inputs.
	assign ref_tick = s_r.sel_aux ? (AUX_REFERENCE_INPUT && !s_r.ref_prev[1])
		: (CRYSTAL_OR_REF_INPUT && !s_r.ref_prev[0]);
	assign vco_tick = VCO_CLK & ~s_r.vco_prev;
	assign status = {4'h0, s_r.pwr, s_r.sel_aux};

	// Next-state logic for registers, reference mux and all dividers.
	always_comb
	begin
		logic [1:0] src;
		logic live;
		src = 2'h0;
		live = 1'b0;
		s_nxt = s_r;
		s_nxt.ref_prev = {AUX_REFERENCE_INPUT, CRYSTAL_OR_REF_INPUT};
		s_nxt.vco_prev = VCO_CLK;
		s_nxt.pfd = '0;
		s_nxt.rdata = reg_read(s_r.cfg, status, CFG_ADDR);
		// Register writes land in the software copy only.
		if (CFG_WR)
		begin
			case (CFG_ADDR)
				PRD_ADDR_DRIVE: s_nxt.cfg.drive = CFG_WDATA[1:0];
				PRD_ADDR_LOAD: s_nxt.cfg.cap = CFG_WDATA;
				PRD_ADDR_REFSEL:
				begin
					s_nxt.cfg.primsel = CFG_WDATA[PRD_PRIM_BIT];
					s_nxt.cfg.swmode = CFG_WDATA[PRD_SM_LSB +: 2];
				end
				PRD_ADDR_MFC: s_nxt.cfg.manual_frequency_control = CFG_WDATA[1:0];
				PRD_ADDR_OUT1SRC: s_nxt.cfg.out1src = CFG_WDATA[1:0];
				default: ;
			endcase
			for (int p = 0; p < PRD_NUM_PLL; p++)
			begin
				if (CFG_ADDR == PRD_ADDR_PRE0 + 8'(p))
					s_nxt.cfg.pre[p] = CFG_WDATA;
				if (CFG_ADDR == PRD_ADDR_FB0 + 8'(2 * p))
					s_nxt.cfg.n[p][7:0] = CFG_WDATA;
				if (CFG_ADDR == PRD_ADDR_FB0 + 8'(2 * p + 1))
					s_nxt.cfg.n[p][11:8] = CFG_WDATA[3:0];
			end
			for (int p = 0; p < PRD_NUM_SS; p++)
			begin
				if (CFG_ADDR == PRD_ADDR_FB0 + 8'(2 * p + 1))
					s_nxt.cfg.a[p] = CFG_WDATA[PRD_A_LSB +: 4];
				if (CFG_ADDR == PRD_ADDR_TSSC0 + 8'(p) * PRD_ADDR_SS_STRIDE)
					s_nxt.cfg.tssc[p] = CFG_WDATA[3:0];
				if (CFG_ADDR == PRD_ADDR_SSOFF0 + 8'(p) * PRD_ADDR_SS_STRIDE)
					s_nxt.cfg.ssoff[p] = CFG_WDATA[5:0];
			end
			for (int k = 0; k < PRD_NUM_BANK; k++)
			begin
				if (CFG_ADDR == PRD_ADDR_POST0 + 8'(2 * k))
					s_nxt.cfg.q[k][7:0] = CFG_WDATA;
				if (CFG_ADDR == PRD_ADDR_POST0 + 8'(2 * k + 1))
				begin
					s_nxt.cfg.q[k][9:8] = CFG_WDATA[1:0];
					s_nxt.cfg.src[k] = CFG_WDATA[PRD_SRC_LSB +: 2];
				end
			end
		end
		// The active copy and the mux follow software only on a reference edge.
		// No shadowing beyond that: a half-written divider may glitch outputs.
		if (ref_tick)
		begin
			s_nxt.act = s_r.cfg;
			s_nxt.sel_aux = want_aux(s_r.cfg, GENERAL_INPUT_FIVE);
		end
		// Pre-scalers count reference edges; zero stops the PLL.
		for (int p = 0; p < PRD_NUM_PLL; p++)
		begin
			s_nxt.pwr[p] = s_r.act.pre[p] != 8'h00;
			if (s_r.act.pre[p] == 8'h00)
				s_nxt.pre_cnt[p] = 8'h00;
			else if (ref_tick)
			begin
				if (s_r.pre_cnt[p] + 8'h01 >= s_r.act.pre[p])
				begin
					s_nxt.pre_cnt[p] = 8'h00;
					s_nxt.pfd[p] = 1'b1;
				end
				else
					s_nxt.pre_cnt[p] = s_r.pre_cnt[p] + 8'h01;
			end
		end
		// Banks 2-6: half period of Q+2 oscillator edges, then a toggle.
		for (int k = 0; k < PRD_NUM_BANK; k++)
		begin
			src = s_r.act.src[k];
			live = (src != PRD_SRC_NONE) && s_r.pwr[src];
			if (!live)
			begin
				s_nxt.post_cnt[k] = 11'h000;
				s_nxt.bank[k] = 1'b0;
			end
			else if (vco_tick[src])
			begin
				if (s_r.post_cnt[k] >= {1'b0, s_r.act.q[k]} + 11'h001)
				begin
					s_nxt.post_cnt[k] = 11'h000;
					s_nxt.bank[k] = !s_r.bank[k];
				end
				else
					s_nxt.post_cnt[k] = s_r.post_cnt[k] + 11'h001;
			end
		end
		// Bank 1 follows its PLL oscillator with no division at all.
		src = s_r.act.out1src;
		s_nxt.out1 = (src != PRD_SRC_NONE) && s_r.pwr[src] && VCO_CLK[src];
		for (int p = 0; p < PRD_NUM_SS; p++)
			s_nxt.fb[p] = fb_x64(s_r.act.n[p], s_r.act.a[p], s_r.act.ssoff[p],
				s_r.act.tssc[p]);
		s_nxt.fb2 = s_r.act.n[2];
		s_nxt.load = PRD_LOAD_BASE + {1'b0, s_r.cfg.cap};
	end

	// State register.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			s_r <= '{cfg: PRD_CFG_RST, act: PRD_CFG_RST, pwr: '1, load: PRD_LOAD_BASE,
				default: '0};
		else
			s_r <= s_nxt;
	end

	// Outputs straight from the state register.
	assign CFG_RDATA = s_r.rdata;
	assign REF_SELECT_AUX = s_r.sel_aux;
	assign PFD_TICK = s_r.pfd;
	assign PLL_POWERED = s_r.pwr;
	assign FB_RATIO0_X64 = s_r.fb[0];
	assign FB_RATIO1_X64 = s_r.fb[1];
	assign FB_RATIO2 = s_r.fb2;
	assign CRYSTAL_LOAD_EIGHTHS_PF = s_r.load;
	assign CRYSTAL_DRIVE_STRENGTH = s_r.cfg.drive;
	assign OUT1_CLK = s_r.out1;
	assign BANK_CLK = s_r.bank;

	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	// A reference edge followed by the adoption step.
	sequence ref_edge_s;
		ref_tick;
	endsequence
	sequence adopt_s;
		##1 (s_r.act == $past(s_r.cfg));
	endsequence

	apply_on_edge_a: assert property (ref_edge_s |-> adopt_s)
		else $error("settings not adopted on reference edge");
	ref_choice_a: assert property (ref_edge_s |=>
		REF_SELECT_AUX == ($past(s_r.cfg.primsel) ^ ($past(GENERAL_INPUT_FIVE)
		&& !$past(s_r.cfg.swmode[1]) && $past(s_r.cfg.manual_frequency_control) != PRD_MFC_NO_PIN)))
		else $error("reference selection wrong");
	mfc_pin_ignored_a: assert property ((ref_tick && s_r.cfg.manual_frequency_control == PRD_MFC_NO_PIN) |=>
		REF_SELECT_AUX == $past(s_r.cfg.primsel))
		else $error("select pin acted in mode 2");
	load_cap_a: assert property (##1 CRYSTAL_LOAD_EIGHTHS_PF ==
		PRD_LOAD_BASE + {1'b0, $past(s_r.cfg.cap)})
		else $error("load capacitance code wrong");
	pre_off_a: assert property ((s_r.act.pre[1] == 8'h00) |=> (!PFD_TICK[1]
		&& !PLL_POWERED[1]))
		else $error("PLL1 not powered down");
	pfd_cause_a: assert property (PFD_TICK[1] |-> $past(ref_tick)
		&& $past(s_r.act.pre[1]) != 8'h00)
		else $error("pre-scaler pulse without reference edge");
	fine_minus_a: assert property ((s_r.act.a[0] == 4'h0) |=>
		FB_RATIO0_X64[19:6] == {1'b0, $past(s_r.act.n[0]), 1'b0})
		else $error("fine code zero not minus one");
	spread_frac_a: assert property (##1 FB_RATIO1_X64[5:0] ==
		(($past(s_r.act.tssc[1]) != 4'h0) ? $past(s_r.act.ssoff[1]) : 6'h00))
		else $error("spread offset folding wrong");
	pll2_ratio_a: assert property (##1 FB_RATIO2 == $past(s_r.act.n[2]))
		else $error("PLL2 ratio not coarse value");
	bank_toggle_a: assert property ($changed(BANK_CLK[0]) |-> $past(s_r.act.src[0] == PRD_SRC_NONE
		|| !s_r.pwr[s_r.act.src[0]] || vco_tick[s_r.act.src[0]]))
		else $error("bank toggled without oscillator edge");
endmodule

// File: verification/prd_host.sv
`timescale 1ns/1ps
// Configuration host model: one-cycle register writes, bus parked between them.
module prd_host
	import prd_pkg::*;
(
	// Clock.
	CLK,
	// Configuration port.
	CFG_WR,
	CFG_ADDR,
	CFG_WDATA
);
	input wire logic CLK;
	output logic CFG_WR;
	output logic [7:0] CFG_ADDR;
	output logic [7:0] CFG_WDATA;

	// Idle bus at time zero.
	initial
	begin
		CFG_WR = 1'b0;
		CFG_ADDR = 8'h00;
		CFG_WDATA = 8'h00;
	end

	// One write; the address is left in place so the byte can be read back.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		// Manual switchover only, so the mode field keeps its upper bit clear.
		if (a == PRD_ADDR_REFSEL)
			d[7] = 1'b0;
		// The reference is an external clock, so the drive stays at its default.
		if (a == PRD_ADDR_DRIVE)
			d[1:0] = PRD_DRIVE_RST;
		@(posedge CLK);
		#1;
		CFG_WR = 1'b1;
		CFG_ADDR = a;
		CFG_WDATA = d;
		@(posedge CLK);
		#1;
		CFG_WR = 1'b0;
		// Released data is scrambled so that a late sample cannot look right.
		CFG_WDATA = ~d;
	endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; $display("[ERR] %0t mismatch %h exp %h", $time, a, e); end end
module tb
	import prd_pkg::*;
;
	// One table row: pin level, register write and the output expected after it.
	typedef struct packed {
		logic pin;
		logic [7:0] addr;
		logic [7:0] data;
		logic [2:0] sel;
		logic [19:0] exp;
	} prd_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic crystal = 1'b0;
	logic aux = 1'b0;
	logic pin = 1'b0;
	logic vco = 1'b0;
	logic run = 1'b1;
	logic phase = 1'b0;
	logic cfg_wr;
	logic [7:0] cfg_addr;
	logic [7:0] cfg_wdata;
	logic [7:0] cfg_rdata;
	logic ref_aux;
	logic [2:0] pfd;
	logic [2:0] pwr;
	logic [19:0] fb0;
	logic [19:0] fb1;
	logic [11:0] fb2;
	logic [8:0] load;
	logic [1:0] drive;
	logic out1;
	logic [4:0] bank;
	int err_total = 0;
	int compares = 0;
	int p;
	// Host-side traffic in order; the divided reference stays far above the floor.
	localparam prd_row_t ROWS[23] = '{
		'{1'b0, 8'h07, 8'h00, 3'h0, 20'h0001c},
		'{1'b0, 8'h07, 8'hff, 3'h0, 20'h0011b},
		'{1'b0, 8'h07, 8'ha5, 3'h6, 20'h000a5},
		'{1'b0, 8'h06, 8'h00, 3'h6, 20'h00003},
		'{1'b0, 8'h18, 8'h20, 3'h1, 20'((2*32-1+1)*64)},
		'{1'b0, 8'h19, 8'h30, 3'h1, 20'((2*32+3+1)*64)},
		'{1'b0, 8'h19, 8'h10, 3'h1, 20'((2*32+1+1)*64)},
		'{1'b0, 8'h60, 8'h05, 3'h1, 20'((2*32+1+1)*64)},
		'{1'b0, 8'h61, 8'h10, 3'h1, 20'((2*32+1+1)*64+16)},
		'{1'b0, 8'h60, 8'h00, 3'h1, 20'((2*32+1+1)*64)},
		'{1'b0, 8'h1c, 8'hff, 3'h3, 20'h000ff},
		'{1'b0, 8'h1d, 8'h0f, 3'h3, 20'h00fff},
		'{1'b0, 8'h11, 8'h00, 3'h4, 20'h00005},
		'{1'b0, 8'h11, 8'h01, 3'h4, 20'h00007},
		'{1'b0, 8'h34, 8'h01, 3'h5, 20'h00001},
		'{1'b1, 8'h34, 8'h01, 3'h5, 20'h00000},
		'{1'b1, 8'h35, 8'h02, 3'h5, 20'h00001},
		'{1'b1, 8'h35, 8'h00, 3'h5, 20'h00000},
		'{1'b1, 8'h34, 8'hc1, 3'h5, 20'h00000},
		'{1'b0, 8'h34, 8'h00, 3'h5, 20'h00000},
		'{1'b1, 8'h34, 8'h00, 3'h5, 20'h00001},
		'{1'b1, 8'h36, 8'h00, 3'h6, 20'h0000f},
		'{1'b0, 8'h50, 8'hff, 3'h6, 20'h00000}};

	always #5 clk = ~clk;

	// References toggle every cycle while running; the oscillators every second cycle.
	always @(posedge clk)
	begin
		#1;
		if (run)
		begin
			crystal = ~crystal;
			aux = ~aux;
		end
		phase = ~phase;
		if (phase)
			vco = ~vco;
	end

	prd_host host_u (.CLK(clk), .CFG_WR(cfg_wr), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata));

	prd_top dut_u (.CLK(clk), .RESET(rst), .CFG_WR(cfg_wr), .CFG_ADDR(cfg_addr),
		.CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .CRYSTAL_OR_REF_INPUT(crystal),
		.AUX_REFERENCE_INPUT(aux), .GENERAL_INPUT_FIVE(pin), .VCO_CLK({3{vco}}),
		.REF_SELECT_AUX(ref_aux), .PFD_TICK(pfd), .PLL_POWERED(pwr), .FB_RATIO0_X64(fb0),
		.FB_RATIO1_X64(fb1), .FB_RATIO2(fb2), .CRYSTAL_LOAD_EIGHTHS_PF(load),
		.CRYSTAL_DRIVE_STRENGTH(drive), .OUT1_CLK(out1), .BANK_CLK(bank));

	// Picks the output that a table row looks at.
	function automatic logic [19:0] obs(input logic [2:0] s);
		case (s)
			3'h0: obs = {11'h000, load};
			3'h1: obs = fb0;
			3'h3: obs = {8'h00, fb2};
			3'h4: obs = {17'h00000, pwr};
			3'h5: obs = {19'h00000, ref_aux};
			default: obs = {12'h000, cfg_rdata};
		endcase
	endfunction

	// Clock-like output chosen for period measurement.
	function automatic logic sig(input int s);
		sig = (s == 0) ? out1 : ((s == 1) ? bank[0] : pfd[0]);
	endfunction

	// Waits for a rising level, counting cycles; gives up at 400.
	task automatic edge_up(input int s, inout int n);
		while (sig(s) !== 1'b0 && n < 400)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (sig(s) !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	// Rise-to-rise period in cycles; 400 means the output never rose.
	task automatic meas(input int s, output int q);
		int n;
		n = 0;
		edge_up(s, n);
		n = 0;
		edge_up(s, n);
		q = n;
	endtask

	task automatic end_sim();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog well beyond the expected twelve hundred or so cycles.
	initial
	begin
		#100000;
		err_total++;
		end_sim();
	end

	// Main sequence: table first, then timing, hold-off and reset cases.
	initial
	begin
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		foreach (ROWS[i])
		begin
			pin = ROWS[i].pin;
			host_u.wr(ROWS[i].addr, ROWS[i].data);
			repeat (8) @(posedge clk);
			#1;
			`CHK(obs(ROWS[i].sel), ROWS[i].exp)
			$display("row %0d done", i);
		end
		pin = 1'b0;
		host_u.wr(8'h34, 8'h00);
		meas(0, p);
		`CHK(p, 4)
		meas(1, p);
		`CHK(p, 2*(0+2)*4)
		host_u.wr(8'h20, 8'h01);
		meas(1, p);
		meas(1, p);
		`CHK(p, 2*(1+2)*4)
		meas(2, p);
		`CHK(p, 2)
		host_u.wr(8'h10, 8'h03);
		meas(2, p);
		meas(2, p);
		`CHK(p, 3*2)
		host_u.wr(8'h21, 8'h30);
		meas(1, p);
		`CHK(p, 400)
		$display("period test done");
		run = 1'b0;
		host_u.wr(8'h12, 8'h00);
		repeat (6) @(posedge clk);
		#1;
		`CHK(pwr, 3'h7)
		run = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		`CHK(pwr, 3'h3)
		$display("hold-off test done");
		@(posedge clk);
		#1;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		`CHK({load, drive, pwr, ref_aux, out1, bank, cfg_rdata}, {9'h01c, 2'h3, 3'h7, 15'h0000})
		@(posedge clk);
		#1;
		rst = 1'b0;
		// First edge after release: reset settings already drive the outputs.
		@(posedge clk);
		#1;
		`CHK({pwr, load, ref_aux}, {3'h7, 9'h01c, 1'b0})
		// Second edge: the ratios follow the cleared coarse values.
		@(posedge clk);
		#1;
		`CHK({pwr, fb0, fb2}, {3'h7, 20'h00000, 12'h000})
		$display("reset test done");
		end_sim();
	end
endmodule
